// ==== rtl/dra_ram_access.sv ====
// Contract
// - sample pacing runs at 9600 Hz always; baud pacing follows the configuration.
// - each channel tests its request once per baud if rate set, else per sample.
// - address bits 0-6 pick location, bit 7 picks real (0) or imaginary (1) bank.
// - coefficient select clear uses data RAM, set uses coefficient RAM.
// - in parallel mode only channel 1 is offered; offset 10h is the byte buffer.
// - a RAM read moves real and imaginary words together into the data registers.
// - completion sets done; with irq enable also sets source and raises interrupt.
// - host reads real high, real low, imag high, imag low; last read clears flags.
// - a RAM write moves one 16-bit imaginary register word into the addressed bank.
// - reading or writing imag low byte clears done and source after a write.
// - parallel receive stores a byte every eight bit times and sets channel 2 done.
// - parallel receive clears channel 2 done when host reads the byte buffer.
// - host must read within eight bit times or the byte is overwritten.
// - oldest received bit sits in the LSB, newest in the MSB.
// - parallel transmit fetches the buffer every eight bit times, then sets done.
// - parallel transmit clears channel 2 done when host writes the byte buffer.
// - if no new byte is written in time, the held byte is sent again.
// - buffered byte goes out bit 0 first, bit 7 last.
// - extra HDLC flag count lives in imaginary coefficient RAM location 85.
// - write select copies imag pair to RAM; clear reads location into both registers.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module dra_ram_access
    import dra_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // modem core pacing and serial data
    input wire logic baud_strobe,
    input wire logic bit_strobe,
    input wire logic rx_bit,
    output logic tx_bit,
    // status to host and core
    output logic irq,
    output logic [15:0] hdlc_flags
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dra_state_t q;
    dra_state_t d;
    dra_ram_wr_t [1:0] ram_wr;
    logic [15:0] ram_q [4][128];
    logic [1:0] pace;
    logic [1:0] ch_live;
    logic [1:0][15:0] rd_re;
    logic [1:0][15:0] rd_im;

    // bank index is {coefficient select, imaginary}
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            pace[i] = q.ch[i].rate ? baud_strobe : q.sample_tick;
            ch_live[i] = (i == 0) || !q.parallel_mode_enable;
            rd_re[i] = ram_q[{q.ch[i].coef, 1'b0}][q.ch[i].adr[6:0]];
            rd_im[i] = ram_q[{q.ch[i].coef, 1'b1}][q.ch[i].adr[6:0]];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic acc;
        logic rd_done;
        logic wr_done;
        logic mapped;
        logic [7:0] idx;
        logic [7:0] rd;
        logic [7:0] wb;
        logic hit;
        logic [3:0] off;
        acc = psel && penable;
        rd_done = acc && q.pready && !pwrite;
        wr_done = acc && q.pready && pwrite;
        idx = paddr[9:2];
        wb = pwdata[7:0];
        mapped = 1'b0;
        rd = BYTE_RESET;
        hit = 1'b0;
        off = 4'h0;
        d = q;
        ram_wr = '0;

        // sample pacing, independent of configuration
        d.sample_tick = 1'b0;
        if (q.sample_cnt == 16'(SAMPLE_DIV - 1))
        begin
            d.sample_cnt = 16'h0000;
            d.sample_tick = 1'b1;
        end
        else
        begin
            d.sample_cnt = q.sample_cnt + 16'h0001;
        end

        // read mux
        // channel 2 registers drop out in parallel mode, index 10h is then the buffer
        if (paddr[11:10] == 2'b00)
        begin
            if (idx == IDX_MODE)
            begin
                mapped = 1'b1;
                rd = {6'h00, q.ptx, q.parallel_mode_enable};
            end
            else if (idx == IDX_DBUF && q.parallel_mode_enable)
            begin
                mapped = 1'b1;
                rd = q.dbuf;
            end
            else if (idx[7:5] == 3'b000 && ch_live[idx[4]])
            begin
                mapped = 1'b1;
                case (idx[3:0])
                    IDX_IMAG_LO[3:0]: rd = q.ch[idx[4]].im[7:0];
                    IDX_IMAG_HI[3:0]: rd = q.ch[idx[4]].im[15:8];
                    IDX_REAL_LO[3:0]: rd = q.ch[idx[4]].re[7:0];
                    IDX_REAL_HI[3:0]: rd = q.ch[idx[4]].re[15:8];
                    IDX_CTRL[3:0]: rd = {3'b000, q.ch[idx[4]].irq_en, q.ch[idx[4]].rate,
                                         q.ch[idx[4]].coef, q.ch[idx[4]].wt, q.ch[idx[4]].ra};
                    IDX_ADDR[3:0]: rd = q.ch[idx[4]].adr;
                    IDX_STAT[3:0]: rd = {6'h00, q.ch[idx[4]].src, q.ch[idx[4]].done};
                    default: mapped = 1'b0;
                endcase
            end
        end

        // apb answer: one wait state, effects at the completing edge
        if (acc && !q.pready)
        begin
            d.pready = 1'b1;
            d.pslverr = !mapped;
            d.prdata = {24'h000000, rd};
        end
        else
        begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
        end

        // mode register
        if (wr_done && mapped && idx == IDX_MODE)
        begin
            d.parallel_mode_enable = wb[MODE_PARALLEL_MODE_ENABLE_BIT];
            d.ptx = wb[MODE_PTX_BIT];
        end

        // ------------------------------------------------------------
        // access channels
        // ------------------------------------------------------------
        for (int i = 0; i < 2; i++)
        begin
            hit = mapped && ch_live[i] && (idx[7:4] == 4'(i)) && idx != IDX_MODE;
            off = idx[3:0];
            if (wr_done && hit)
            begin
                case (off)
                    IDX_IMAG_LO[3:0]:
                    begin
                        d.ch[i].im[7:0] = wb;
                        d.ch[i].done = 1'b0;
                        d.ch[i].src = 1'b0;
                    end
                    IDX_IMAG_HI[3:0]: d.ch[i].im[15:8] = wb;
                    IDX_REAL_LO[3:0]: d.ch[i].re[7:0] = wb;
                    IDX_REAL_HI[3:0]: d.ch[i].re[15:8] = wb;
                    IDX_CTRL[3:0]:
                    begin
                        d.ch[i].ra = wb[CTRL_RA_BIT];
                        d.ch[i].wt = wb[CTRL_WT_BIT];
                        d.ch[i].coef = wb[CTRL_COEF_BIT];
                        d.ch[i].rate = wb[CTRL_RATE_BIT];
                        d.ch[i].irq_en = wb[CTRL_IRQEN_BIT];
                    end
                    IDX_ADDR[3:0]: d.ch[i].adr = wb;
                    default: d.ch[i].adr = d.ch[i].adr;
                endcase
            end
            // last read of the sequence releases the channel
            if (rd_done && hit && off == IDX_IMAG_LO[3:0])
            begin
                d.ch[i].done = 1'b0;
                d.ch[i].src = 1'b0;
            end
            // one transfer per request; done blocks repeats until cleared
            if (ch_live[i] && q.ch[i].ra && !q.ch[i].done && pace[i])
            begin
                if (q.ch[i].wt)
                begin
                    ram_wr[i].we = 1'b1;
                    ram_wr[i].bank = {q.ch[i].coef, q.ch[i].adr[ADR_BANK_BIT]};
                    ram_wr[i].adr = q.ch[i].adr[6:0];
                    ram_wr[i].data = q.ch[i].im;
                end
                else
                begin
                    d.ch[i].re = rd_re[i];
                    d.ch[i].im = rd_im[i];
                end
                d.ch[i].done = 1'b1;
                if (q.ch[i].irq_en)
                begin
                    d.ch[i].src = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // parallel byte buffer, uses channel 2 flags
        // ------------------------------------------------------------
        if (q.parallel_mode_enable)
        begin
            if (rd_done && idx == IDX_DBUF && !q.ptx)
            begin
                d.ch[1].done = 1'b0;
                d.ch[1].src = 1'b0;
            end
            if (wr_done && idx == IDX_DBUF && q.ptx)
            begin
                d.dbuf = wb;
                d.ch[1].done = 1'b0;
                d.ch[1].src = 1'b0;
            end
            if (bit_strobe)
            begin
                d.bit_cnt = q.bit_cnt + 3'd1;
                if (q.ptx)
                begin
                    d.tx_bit = q.shift[0];
                    d.shift = {1'b0, q.shift[7:1]};
                    if (q.bit_cnt == 3'd7)
                    begin
                        // an unrefreshed buffer is simply fetched again
                        d.shift = d.dbuf;
                        d.ch[1].done = 1'b1;
                        d.ch[1].src = q.ch[1].irq_en;
                    end
                end
                else
                begin
                    d.shift = {rx_bit, q.shift[7:1]};
                    if (q.bit_cnt == 3'd7)
                    begin
                        // overwrites an unread byte: the host lost it
                        d.dbuf = {rx_bit, q.shift[7:1]};
                        d.ch[1].done = 1'b1;
                        d.ch[1].src = q.ch[1].irq_en;
                    end
                end
            end
        end
        else
        begin
            d.bit_cnt = 3'd0;
        end

        if (q.sample_tick)
        begin
            d.hdlc_flags = ram_q[{1'b1, HDLC_FLAGS_ADR[ADR_BANK_BIT]}][HDLC_FLAGS_ADR[6:0]];
        end

        d.irq = d.ch[0].src || d.ch[1].src;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // dsp ram carries no reset; channel 2 port is applied last
    always_ff @(posedge pclk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (ram_wr[i].we)
            begin
                ram_q[ram_wr[i].bank][ram_wr[i].adr] <= ram_wr[i].data;
            end
        end
    end

    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
    assign tx_bit = q.tx_bit;
    assign irq = q.irq;
    assign hdlc_flags = q.hdlc_flags;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sample_pace_a: assert property (q.sample_cnt == 16'(SAMPLE_DIV - 1)
        |=> q.sample_tick && q.sample_cnt == 16'h0000)
        else $error("sample tick not at end of period");
    ch1_done_a: assert property (q.ch[0].ra && !q.ch[0].done && pace[0] |=> q.ch[0].done)
        else $error("channel 1 transfer did not set done");
    ch1_hold_a: assert property (!q.ch[0].done && !pace[0] |=> !q.ch[0].done)
        else $error("channel 1 transfer outside its pacing");
    ch2_done_a: assert property (!q.parallel_mode_enable && q.ch[1].ra && !q.ch[1].done && pace[1] |=> q.ch[1].done)
        else $error("channel 2 transfer did not set done");
    ch2_hold_a: assert property (!q.parallel_mode_enable && !q.ch[1].done && !pace[1] |=> !q.ch[1].done)
        else $error("channel 2 transfer outside its pacing");
    read_pair_a: assert property (q.ch[0].ra && !q.ch[0].done && pace[0] && !q.ch[0].wt
        |=> q.ch[0].re == $past(rd_re[0]) && q.ch[0].im == $past(rd_im[0]))
        else $error("read did not load both words");
    write_port_a: assert property (ram_wr[0].we |-> ram_wr[0].data == q.ch[0].im
        && ram_wr[0].bank == {q.ch[0].coef, q.ch[0].adr[7]})
        else $error("write took wrong word or bank");
    ch1_wclr_a: assert property (psel && penable && pwrite && q.pready && paddr == 12'h000
        && !(q.ch[0].ra && !q.ch[0].done && pace[0]) |=> !q.ch[0].done && !q.ch[0].src)
        else $error("imaginary low write did not release channel 1");
    ch2_rclr_a: assert property (!q.parallel_mode_enable && psel && penable && !pwrite && q.pready && paddr == 12'h040
        && !(q.ch[1].ra && !q.ch[1].done && pace[1]) |=> !q.ch[1].done && !q.ch[1].src)
        else $error("last data read did not release channel 2");
    parallel_mode_enable_ch2_a: assert property (q.parallel_mode_enable |-> !ram_wr[1].we)
        else $error("channel 2 accessed ram in parallel mode");
    ch2_hidden_a: assert property (q.parallel_mode_enable && psel && penable && !q.pready && paddr[11:6] == 6'h01
        && paddr[5:2] != 4'h0 && paddr[5:2] != 4'hf |=> q.pready && q.pslverr)
        else $error("channel 2 register answered in parallel mode");
    irq_track_a: assert property (q.irq == (q.ch[0].src || q.ch[1].src))
        else $error("interrupt disagrees with sources");
    irq_rise_a: assert property (q.ch[0].ra && !q.ch[0].done && pace[0] && q.ch[0].irq_en |=> q.irq)
        else $error("enabled transfer did not raise interrupt");
    rx_byte_a: assert property (q.parallel_mode_enable && !q.ptx && bit_strobe && q.bit_cnt == 3'd7
        |=> q.dbuf == {$past(rx_bit), $past(q.shift[7:1])} && q.ch[1].done)
        else $error("received byte not stored");
    rx_rclr_a: assert property (q.parallel_mode_enable && !q.ptx && psel && penable && !pwrite && q.pready
        && paddr == 12'h040 && !bit_strobe |=> !q.ch[1].done && !q.ch[1].src)
        else $error("buffer read did not clear done");
    tx_order_a: assert property (q.parallel_mode_enable && q.ptx && bit_strobe |=> q.tx_bit == $past(q.shift[0]))
        else $error("transmit bit order wrong");
    tx_reload_a: assert property (q.parallel_mode_enable && q.ptx && bit_strobe && q.bit_cnt == 3'd7
        && !(psel && penable && pwrite && q.pready) |=> q.shift == $past(q.dbuf) && q.ch[1].done)
        else $error("transmit buffer not fetched");
    dbuf_wclr_a: assert property (q.parallel_mode_enable && q.ptx && psel && penable && pwrite && q.pready
        && paddr == 12'h040 && !bit_strobe |=> !q.ch[1].done)
        else $error("buffer write did not clear done");
    apb_wait_a: assert property (psel && penable && !q.pready |=> q.pready ##1 !q.pready)
        else $error("apb answer timing wrong");

endmodule // dra_ram_access

`default_nettype wire

// ==== rtl/dra_pkg.sv ====
package dra_pkg;

    // ------------------------------------------------------------
    // pacing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int SAMPLE_HZ = 9600;
    // longest period rounds down: 20833 cycles
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

    // ------------------------------------------------------------
    // register indexes, byte address is index * 4
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_IMAG_LO = 8'h00;
    localparam logic [7:0] IDX_IMAG_HI = 8'h01;
    localparam logic [7:0] IDX_REAL_LO = 8'h02;
    localparam logic [7:0] IDX_REAL_HI = 8'h03;
    localparam logic [7:0] IDX_CTRL = 8'h05;
    localparam logic [7:0] IDX_ADDR = 8'h06;
    localparam logic [7:0] IDX_STAT = 8'h07;
    localparam logic [3:0] CH2_PAGE = 4'h1;
    localparam logic [7:0] IDX_DBUF = 8'h10;
    localparam logic [7:0] IDX_MODE = 8'h1f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_RA_BIT = 0;
    localparam int CTRL_WT_BIT = 1;
    localparam int CTRL_COEF_BIT = 2;
    localparam int CTRL_RATE_BIT = 3;
    localparam int CTRL_IRQEN_BIT = 4;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_SRC_BIT = 1;
    localparam int MODE_PARALLEL_MODE_ENABLE_BIT = 0;
    localparam int MODE_PTX_BIT = 1;
    localparam int ADR_BANK_BIT = 7;
    localparam logic [7:0] HDLC_FLAGS_ADR = 8'h85;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef struct packed {
        logic ra;
        logic wt;
        logic coef;
        logic rate;
        logic irq_en;
        logic done;
        logic src;
        logic [7:0] adr;
        logic [15:0] re;
        logic [15:0] im;
    } dra_ch_t;

    typedef struct packed {
        dra_ch_t [1:0] ch;
        logic parallel_mode_enable;
        logic ptx;
        logic [15:0] sample_cnt;
        logic sample_tick;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] dbuf;
        logic tx_bit;
        logic irq;
        logic [15:0] hdlc_flags;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dra_state_t;

    typedef struct packed {
        logic we;
        logic [1:0] bank;
        logic [6:0] adr;
        logic [15:0] data;
    } dra_ram_wr_t;

endpackage

// ==== testbench/dra_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module dra_core_model
    import dra_pkg::*;
#(
    parameter int BIT_DIV = 8,
    parameter int BAUD_DIV = 13
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic bit_en,
    input wire logic baud_en,
    input wire logic [15:0] rx_word,
    // modem core side
    output logic baud_strobe,
    output logic bit_strobe,
    output logic rx_bit,
    input wire logic tx_bit,
    output logic [7:0] tx_cap
);
    logic [7:0] bcnt_q;
    logic [7:0] dcnt_q;
    logic [3:0] idx_q;
    logic strobe_d1_q;

    // ----------------------------------------
    // bit and baud pacing, still while disabled
    // ----------------------------------------
    // outside strobe cycles the line shows the inverse so a stale bit never passes
    assign rx_bit = bit_strobe ? rx_word[idx_q] : ~rx_word[idx_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bcnt_q <= 8'h00;
            dcnt_q <= 8'h00;
            idx_q <= 4'h0;
            strobe_d1_q <= 1'b0;
            bit_strobe <= 1'b0;
            baud_strobe <= 1'b0;
            tx_cap <= 8'h00;
        end
        else
        begin
            bcnt_q <= (bit_en && bcnt_q != 8'(BIT_DIV - 1)) ? bcnt_q + 8'h01 : 8'h00;
            bit_strobe <= bit_en && bcnt_q == 8'(BIT_DIV - 1);
            dcnt_q <= (baud_en && dcnt_q != 8'(BAUD_DIV - 1)) ? dcnt_q + 8'h01 : 8'h00;
            baud_strobe <= baud_en && dcnt_q == 8'(BAUD_DIV - 1);
            idx_q <= !bit_en ? 4'h0 : (bit_strobe ? idx_q + 4'h1 : idx_q);
            strobe_d1_q <= bit_strobe;
            if (strobe_d1_q)
            begin
                tx_cap <= {tx_bit, tx_cap[7:1]};
            end
        end
    end
endmodule // dra_core_model

`default_nettype wire

// ==== testbench/dsp_ram_access_and_byte_buffer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
        end \
    end

module dsp_ram_access_and_byte_buffer_bench
    import dra_pkg::*;
;
    localparam int SD = 20;
    localparam int BD = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, baud_strobe, bit_strobe, rx_bit, tx_bit, irq, err;
    logic bit_en = 1'b0;
    logic baud_en = 1'b0;
    logic [15:0] rx_word = 16'h96a5;
    logic [15:0] hdlc_flags;
    logic [7:0] tx_cap, v;
    int miscompares = 0;
    int checked = 0;

    always #2.5 pclk = ~pclk;

    dra_ram_access #(.SAMPLE_DIV(SD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .baud_strobe(baud_strobe), .bit_strobe(bit_strobe), .rx_bit(rx_bit), .tx_bit(tx_bit), .irq(irq),
        .hdlc_flags(hdlc_flags));

    dra_core_model #(.BIT_DIV(BD), .BAUD_DIV(13)) core (.pclk(pclk), .presetn(presetn), .bit_en(bit_en),
        .baud_en(baud_en), .rx_word(rx_word), .baud_strobe(baud_strobe), .bit_strobe(bit_strobe),
        .rx_bit(rx_bit), .tx_bit(tx_bit), .tx_cap(tx_cap));

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            miscompares++;
        v = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
        apb(1'b0, idx, 8'h00);
        `CHK(nm, e, v)
    endtask

    // host preparation sequence, ending with the request itself
    task automatic ram_xfer(input logic [7:0] b, input logic [7:0] ctl, input logic [7:0] adr,
                            input logic [15:0] d);
        apb(1'b1, b + IDX_CTRL, 8'h00);
        apb(1'b0, b + IDX_IMAG_LO, 8'h00);
        apb(1'b1, b + IDX_ADDR, adr);
        apb(1'b1, b + IDX_CTRL, ctl);
        apb(1'b1, b + IDX_IMAG_LO, d[7:0]);
        apb(1'b1, b + IDX_IMAG_HI, d[15:8]);
        apb(1'b1, b + IDX_CTRL, ctl | 8'h01);
    endtask

    task automatic wait_done(input logic [7:0] b);
        int n = 0;
        do
            apb(1'b0, b + IDX_STAT, 8'h00);
        while (v[0] !== 1'b1 && ++n < 100);
        if (v[0] !== 1'b1)
            miscompares++;
    endtask

    task automatic wait_irq();
        int n = 0;
        do
            @(posedge pclk);
        while (irq !== 1'b1 && ++n < 400);
        if (irq !== 1'b1)
            miscompares++;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        end_of_test();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        `CHK("irq in reset", 1'b0, irq)
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 8'h00);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 8'h00, v)
        ram_xfer(8'h00, 8'h16, HDLC_FLAGS_ADR, 16'h1234);
        wait_done(8'h00);
        rchk(IDX_STAT, 8'h03, "ch1 done and source");
        `CHK("irq raised", 1'b1, irq)
        repeat (SD + 4) @(posedge pclk);
        `CHK("hdlc flag count", 16'h1234, hdlc_flags)
        apb(1'b1, IDX_CTRL, 8'h16);
        apb(1'b1, IDX_IMAG_LO, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("irq released", 1'b0, irq)
        rchk(IDX_STAT, 8'h00, "ch1 cleared by write");
        ram_xfer(8'h00, 8'h06, 8'h05, 16'habcd);
        wait_done(8'h00);
        rchk(IDX_STAT, 8'h01, "done without source");
        apb(1'b1, IDX_CTRL, 8'h06);
        apb(1'b0, IDX_IMAG_LO, 8'h00);
        rchk(IDX_STAT, 8'h00, "ch1 cleared by read");
        ram_xfer(8'h00, 8'h02, 8'h85, 16'h6b6b);
        wait_done(8'h00);
        ram_xfer(8'h00, 8'h02, 8'h05, 16'h5a5a);
        wait_done(8'h00);
        // ch2 paced by baud, held off while ch1 runs on sample ticks
        ram_xfer(8'h10, 8'h0c, 8'h05, 16'h0000);
        ram_xfer(8'h00, 8'h00, 8'h05, 16'h0000);
        wait_done(8'h00);
        rchk(8'h17, 8'h00, "ch2 waits for baud");
        rchk(IDX_REAL_HI, 8'h5a, "data real hi");
        rchk(IDX_REAL_LO, 8'h5a, "data real lo");
        rchk(IDX_IMAG_HI, 8'h6b, "data imag hi");
        baud_en <= 1'b1;
        wait_done(8'h10);
        baud_en <= 1'b0;
        rchk(8'h13, 8'hab, "coef real hi");
        rchk(8'h12, 8'hcd, "coef real lo");
        rchk(8'h11, 8'h12, "coef imag hi");
        rchk(8'h10, 8'h34, "coef imag lo");
        rchk(8'h17, 8'h00, "ch2 cleared after reads");
        // parallel receive
        apb(1'b1, 8'h15, 8'h10);
        apb(1'b1, IDX_MODE, 8'h01);
        apb(1'b0, 8'h15, 8'h00);
        `CHK("ch2 hidden", 1'b1, err)
        apb(1'b0, IDX_CTRL, 8'h00);
        `CHK("ch1 offered", 1'b0, err)
        bit_en <= 1'b1;
        wait_irq();
        rchk(IDX_DBUF, 8'ha5, "rx byte");
        repeat (2) @(posedge pclk);
        `CHK("rx done cleared", 1'b0, irq)
        wait_irq();
        repeat (8 * BD + 4) @(posedge pclk);
        rchk(IDX_DBUF, 8'ha5, "rx overrun");
        bit_en <= 1'b0;
        // parallel transmit
        apb(1'b1, IDX_MODE, 8'h00);
        apb(1'b1, IDX_MODE, 8'h03);
        apb(1'b1, IDX_DBUF, 8'hc5);
        bit_en <= 1'b1;
        wait_irq();
        apb(1'b1, IDX_DBUF, 8'h3a);
        repeat (2) @(posedge pclk);
        `CHK("tx done cleared", 1'b0, irq)
        wait_irq();
        repeat (2) @(posedge pclk);
        `CHK("tx byte", 8'hc5, tx_cap)
        repeat (2)
        begin
            repeat (8 * BD) @(posedge pclk);
            `CHK("tx resend", 8'h3a, tx_cap)
        end
        end_of_test();
    end
endmodule // dsp_ram_access_and_byte_buffer_bench

`default_nettype wire
